// ### eis_external_irq_controller.sv
// External interrupt sense controller with its Wishbone register slave.
`timescale 1ns/100ps
`default_nettype none

module eis_external_irq_controller (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // External pins and system state
  input wire logic [15:0] pin_i,
  input wire logic nmi_pin_i,
  input wire logic ulp_clk_i,
  input wire logic standby_i,
  // Interrupts and events
  output logic irq_o,
  output logic nmi_o,
  output logic [15:0] event_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Ordinary byte-lane merge of a write into a stored word.
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Faulty narrow write path of async_edge_select: narrow data is replicated.
  function automatic logic [31:0] async_merge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = lane_merge(old, wd, sel);
    if (sel == 4'h1 || sel == 4'h2 || sel == 4'h4 || sel == 4'h8) begin
      for (int b = 0; b < 4; b++) begin
        if (sel[b]) begin
          r = {4{wd[8*b +: 8]}};
        end
      end
    end else if (sel == eis_pkg::SEL_LO_HALF) begin
      r = {2{wd[15:0]}};
    end else if (sel == eis_pkg::SEL_HI_HALF) begin
      r = {2{wd[31:16]}};
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic en_q, en_d, en_prev_q, en_prev_d, detect_clock_source_q, detect_clock_source_d;
  logic [3:0] nmi_cfg_q, nmi_cfg_d;
  logic nmi_flag_q, nmi_flag_d;
  logic [15:0] flags_q, flags_d, irq_en_q, irq_en_d;
  logic [31:0] async_q, async_d, cfg0_q, cfg0_d, cfg1_q, cfg1_d;
  logic [16:0] pin_s1_q, pin_s1_d, pin_s2_q, pin_s2_d;
  logic ulp_s1_q, ulp_s1_d, ulp_s2_q, ulp_s2_d, ulp_prev_q, ulp_prev_d;
  logic [16:0] hist0_q, hist0_d, hist1_q, hist1_d, hist2_q, hist2_d;
  logic [16:0] level_q, level_d;
  logic [15:0] used_q, used_d, ev_q, ev_d;
  logic irq_q, irq_d;
  logic tick, req, wr, en_rise, nmi_spur;
  logic [16:0] hit;
  logic [15:0] spur;

  // ----------------------------------------------------------------
  // Bus request decode
  // ----------------------------------------------------------------
  // A write takes effect on the edge where ack is high, as the master expects.
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & wb_we_i & ack_q;
  assign en_rise = en_q & ~en_prev_q;
  // Slow ticks only come from the synchronised oscillator, never its first stage.
  assign tick = detect_clock_source_q ? (ulp_s2_q & ~ulp_prev_q) : 1'b1;
  assign nmi_spur = wr && wb_adr_i == eis_pkg::ADDR_NMI_CFG && en_q && wb_sel_i[0]
                    && wb_dat_i[2:0] != nmi_cfg_q[2:0];

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Detection, flags, events and register writes are all computed here.
  always_comb begin
    logic [3:0] cfg;
    logic cur, adv, maj, rise, fall;
    cfg = 4'h0;
    cur = 1'b0;
    adv = 1'b0;
    maj = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    hit = '0;
    spur = '0;
    pin_s1_d = {nmi_pin_i, pin_i};
    pin_s2_d = pin_s1_q;
    ulp_s1_d = ulp_clk_i;
    ulp_s2_d = ulp_s1_q;
    ulp_prev_d = ulp_s2_q;
    en_prev_d = en_q;
    hist0_d = tick ? pin_s2_q : hist0_q;
    hist1_d = tick ? hist0_q : hist1_q;
    hist2_d = tick ? hist1_q : hist2_q;
    level_d = level_q;
    ev_d = '0;
    for (int i = 0; i < eis_pkg::NALL; i++) begin
      if (i == eis_pkg::NMI_IDX) begin
        cfg = nmi_cfg_q;
      end else if (i < eis_pkg::LINES_PER_CFG) begin
        cfg = cfg0_q[eis_pkg::CFG_W*i +: eis_pkg::CFG_W];
      end else begin
        cfg = cfg1_q[eis_pkg::CFG_W*(i-eis_pkg::LINES_PER_CFG) +: eis_pkg::CFG_W];
      end
      // The filter is a three-sample majority taken on the detect clock.
      maj = (hist0_q[i] & hist1_q[i]) | (hist1_q[i] & hist2_q[i]) | (hist0_q[i] & hist2_q[i]);
      cur = cfg[eis_pkg::FILT_BIT] ? maj : pin_s2_q[i];
      // Async lines see every system clock; others wait for the detect clock.
      adv = (i < eis_pkg::NLINES && async_q[i]) ? 1'b1 : tick;
      rise = cur & ~level_q[i];
      fall = ~cur & level_q[i];
      if (adv) begin
        level_d[i] = cur;
      end
      if (en_q && adv) begin
        case (cfg[2:0])
          eis_pkg::SENSE_RISE: hit[i] = rise;
          eis_pkg::SENSE_FALL: hit[i] = fall;
          eis_pkg::SENSE_BOTH: hit[i] = rise | fall;
          eis_pkg::SENSE_HIGH: hit[i] = cur;
          eis_pkg::SENSE_LOW: hit[i] = ~cur;
          default: hit[i] = 1'b0;
        endcase
      end
      if (i < eis_pkg::NLINES) begin
        // Enable-time anomaly of filtered low, rise and both-edge lines.
        spur[i] = en_rise & cfg[eis_pkg::FILT_BIT] & (cfg[2:0] == eis_pkg::SENSE_LOW
                  || cfg[2:0] == eis_pkg::SENSE_RISE || cfg[2:0] == eis_pkg::SENSE_BOTH);
      end
    end
    // In standby an async line gives one event, then stays mute until wake-up.
    for (int i = 0; i < eis_pkg::NLINES; i++) begin
      ev_d[i] = hit[i] & ~(standby_i & async_q[i] & used_q[i]);
      used_d[i] = standby_i & (used_q[i] | (hit[i] & async_q[i]));
    end
    // Register file; a set in the same cycle as a clear wins.
    en_d = en_q;
    detect_clock_source_d = detect_clock_source_q;
    nmi_cfg_d = nmi_cfg_q;
    irq_en_d = irq_en_q;
    async_d = async_q;
    cfg0_d = cfg0_q;
    cfg1_d = cfg1_q;
    flags_d = flags_q;
    nmi_flag_d = nmi_flag_q;
    if (wr) begin
      if (wb_adr_i == eis_pkg::ADDR_CTRL) begin
        if (wb_sel_i[0]) begin
          en_d = wb_dat_i[eis_pkg::CTRL_EN_BIT];
          detect_clock_source_d = wb_dat_i[eis_pkg::CTRL_DETECT_CLOCK_SOURCE_BIT];
        end
      end else if (wb_adr_i == eis_pkg::ADDR_NMI_CFG) begin
        nmi_cfg_d = wb_sel_i[0] ? wb_dat_i[3:0] : nmi_cfg_q;
      end else if (wb_adr_i == eis_pkg::ADDR_NMI_FLAG) begin
        nmi_flag_d = nmi_flag_q & ~(wb_sel_i[0] & wb_dat_i[0]);
      end else if (wb_adr_i == eis_pkg::ADDR_FLAGS) begin
        flags_d = flags_q & ~16'(lane_merge(32'h0, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == eis_pkg::ADDR_ASYNC) begin
        async_d = async_merge(async_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == eis_pkg::ADDR_CFG0) begin
        cfg0_d = lane_merge(cfg0_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == eis_pkg::ADDR_CFG1) begin
        cfg1_d = lane_merge(cfg1_q, wb_dat_i, wb_sel_i);
      end else if (wb_adr_i == eis_pkg::ADDR_IRQ_EN) begin
        irq_en_d = 16'(lane_merge({16'h0, irq_en_q}, wb_dat_i, wb_sel_i));
      end
    end
    flags_d = flags_d | hit[15:0] | spur;
    nmi_flag_d = nmi_flag_d | hit[eis_pkg::NMI_IDX] | nmi_spur;
    irq_d = |(flags_q & irq_en_q);
    // Read data is captured with ack; unmapped offsets read as zero.
    ack_d = req & ~ack_q;
    rdat_d = (req && !ack_q) ? eis_pkg::RESET_WORD : rdat_q;
    if (req && !ack_q) begin
      if (wb_adr_i == eis_pkg::ADDR_CTRL) begin
        rdat_d = {30'h0, detect_clock_source_q, en_q};
      end else if (wb_adr_i == eis_pkg::ADDR_NMI_CFG) begin
        rdat_d = {28'h0, nmi_cfg_q};
      end else if (wb_adr_i == eis_pkg::ADDR_NMI_FLAG) begin
        rdat_d = {31'h0, nmi_flag_q};
      end else if (wb_adr_i == eis_pkg::ADDR_FLAGS) begin
        rdat_d = {16'h0, flags_q};
      end else if (wb_adr_i == eis_pkg::ADDR_ASYNC) begin
        rdat_d = async_q;
      end else if (wb_adr_i == eis_pkg::ADDR_CFG0) begin
        rdat_d = cfg0_q;
      end else if (wb_adr_i == eis_pkg::ADDR_CFG1) begin
        rdat_d = cfg1_q;
      end else if (wb_adr_i == eis_pkg::ADDR_IRQ_EN) begin
        rdat_d = {16'h0, irq_en_q};
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset; every flop takes a constant.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      rdat_q <= eis_pkg::RESET_WORD;
      en_q <= 1'b0;
      en_prev_q <= 1'b0;
      detect_clock_source_q <= 1'b0;
      nmi_cfg_q <= 4'h0;
      nmi_flag_q <= 1'b0;
      flags_q <= 16'h0;
      irq_en_q <= 16'h0;
      async_q <= eis_pkg::RESET_WORD;
      cfg0_q <= eis_pkg::RESET_WORD;
      cfg1_q <= eis_pkg::RESET_WORD;
      pin_s1_q <= 17'h0;
      pin_s2_q <= 17'h0;
      ulp_s1_q <= 1'b0;
      ulp_s2_q <= 1'b0;
      ulp_prev_q <= 1'b0;
      hist0_q <= 17'h0;
      hist1_q <= 17'h0;
      hist2_q <= 17'h0;
      level_q <= 17'h0;
      used_q <= 16'h0;
      ev_q <= 16'h0;
      irq_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      en_q <= en_d;
      en_prev_q <= en_prev_d;
      detect_clock_source_q <= detect_clock_source_d;
      nmi_cfg_q <= nmi_cfg_d;
      nmi_flag_q <= nmi_flag_d;
      flags_q <= flags_d;
      irq_en_q <= irq_en_d;
      async_q <= async_d;
      cfg0_q <= cfg0_d;
      cfg1_q <= cfg1_d;
      pin_s1_q <= pin_s1_d;
      pin_s2_q <= pin_s2_d;
      ulp_s1_q <= ulp_s1_d;
      ulp_s2_q <= ulp_s2_d;
      ulp_prev_q <= ulp_prev_d;
      hist0_q <= hist0_d;
      hist1_q <= hist1_d;
      hist2_q <= hist2_d;
      level_q <= level_d;
      used_q <= used_d;
      ev_q <= ev_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign irq_o = irq_q;
  assign nmi_o = nmi_flag_q;
  assign event_o = ev_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  async_byte_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && wb_adr_i == eis_pkg::ADDR_ASYNC && wb_sel_i == 4'h1)
    |=> async_q == {4{$past(wb_dat_i[7:0])}})
    else $error("byte write to async select not replicated");
  async_half_a: assert property (@(posedge clk) disable iff (!rst_n)
    (wr && wb_adr_i == eis_pkg::ADDR_ASYNC && wb_sel_i == eis_pkg::SEL_HI_HALF)
    |=> async_q == {2{$past(wb_dat_i[31:16])}})
    else $error("upper halfword write to async select not replicated");
  spur_enable_a: assert property (@(posedge clk) disable iff (!rst_n)
    en_rise |=> ((flags_q & $past(spur)) == $past(spur)))
    else $error("enable-time flag missing");
  nmi_change_a: assert property (@(posedge clk) disable iff (!rst_n)
    nmi_spur |=> nmi_flag_q ##1 nmi_o)
    else $error("sense change did not raise nonmaskable flag");
  standby_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(|(ev_q & $past(used_q & async_q[15:0] & {16{standby_i}}))))
    else $error("second async event in standby");
  sync_edge_a: assert property (@(posedge clk) disable iff (!rst_n)
    !tick |=> ((ev_q & ~$past(async_q[15:0])) == 16'h0))
    else $error("sync line fired without detect tick");
  slow_tick_a: assert property (@(posedge clk) disable iff (!rst_n)
    (detect_clock_source_q && !tick) |=> $stable(hist0_q))
    else $error("filter sampled without slow tick");
  disabled_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    !en_q |=> (ev_q == 16'h0))
    else $error("event while disabled");
  flag_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(wr && wb_adr_i == eis_pkg::ADDR_FLAGS)
    |=> ((flags_q & $past(flags_q)) == $past(flags_q)))
    else $error("flag dropped without a clear write");

endmodule

`default_nettype wire

// ### eis_pin_model.sv
// Behavioural model of the external pins, the slow oscillator and the event sink.
`timescale 1ns/100ps
`default_nettype none

module eis_pin_model (
  // Clock and oscillator control
  input wire logic clk,
  input wire logic ulp_run,
  // Event lines from the controller
  input wire logic [15:0] event_i,
  // Pins towards the controller, and the event count towards the testbench
  output logic [15:0] pin_o,
  output logic nmi_o,
  output logic ulp_o,
  output int ev_cnt
);
  logic [1:0] div_q;

  initial begin
    pin_o = 16'hffff;
    nmi_o = 1'b0;
    ulp_o = 1'b0;
    div_q = 2'h0;
    ev_cnt = 0;
  end

  // The oscillator parks low when stopped, so a restart always begins with a rising tick.
  always @(posedge clk) begin
    if (ulp_run) begin
      div_q <= div_q + 2'h1;
      if (div_q == 2'h3) begin
        ulp_o <= ~ulp_o;
      end
    end else begin
      ulp_o <= 1'b0;
    end
    ev_cnt <= ev_cnt + $countones(event_i);
  end

  // A pin changes only just after a clock edge.
  task automatic set_pin(input int idx, input logic v);
    @(posedge clk);
    pin_o[idx] <= v;
  endtask

  // The nonmaskable line moves the same way, just after a clock edge.
  task automatic set_nmi(input logic v);
    @(posedge clk);
    nmi_o <= v;
  endtask
endmodule

`default_nettype wire

// ### eis_pkg.sv
// Package of register map, field layout and encodings for the external interrupt sense block.
package eis_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NLINES = 16;
  localparam int NALL = 17;
  localparam int NMI_IDX = 16;
  localparam int CFG_W = 4;
  localparam int LINES_PER_CFG = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_NMI_CFG = 8'h04;
  localparam logic [7:0] ADDR_NMI_FLAG = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_ASYNC = 8'h10;
  localparam logic [7:0] ADDR_CFG0 = 8'h14;
  localparam logic [7:0] ADDR_CFG1 = 8'h18;
  localparam logic [7:0] ADDR_IRQ_EN = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DETECT_CLOCK_SOURCE_BIT = 1;
  localparam int FILT_BIT = 3;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [3:0] SEL_ALL = 4'hf;
  localparam logic [3:0] SEL_LO_HALF = 4'h3;
  localparam logic [3:0] SEL_HI_HALF = 4'hc;

  // ----------------------------------------------------------------
  // Sense encodings of a line_sense_kind field
  // ----------------------------------------------------------------
  localparam logic [2:0] SENSE_NONE = 3'h0;
  localparam logic [2:0] SENSE_RISE = 3'h1;
  localparam logic [2:0] SENSE_FALL = 3'h2;
  localparam logic [2:0] SENSE_BOTH = 3'h3;
  localparam logic [2:0] SENSE_HIGH = 3'h4;
  localparam logic [2:0] SENSE_LOW = 3'h5;

endpackage

// ### testbench.sv
// Self-checking testbench of the external interrupt sense controller.
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic clk = 1'b0;
  logic rst_n, cyc, stb, we, standby, ulp_run, ack, irq, nmi, nmi_pin, ulp;
  logic [7:0] adr, seed, hb;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, dat_o, q, cfg;
  logic [15:0] pins, ev;
  int ev_cnt, error_cnt, n_checks, base;

  always #2.5 clk = ~clk;

  eis_external_irq_controller dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .pin_i(pins), .nmi_pin_i(nmi_pin), .ulp_clk_i(ulp), .standby_i(standby),
    .irq_o(irq), .nmi_o(nmi), .event_o(ev));

  eis_pin_model pm_u (.clk(clk), .ulp_run(ulp_run), .event_i(ev), .pin_o(pins),
    .nmi_o(nmi_pin), .ulp_o(ulp), .ev_cnt(ev_cnt));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Flags expected with pins high: level-high lines always, filtered low/rise/both at enable.
  function automatic logic [31:0] spur(input logic [31:0] c, input bit at_en);
    logic [2:0] s;
    logic [31:0] f;
    f = 32'h0;
    for (int k = 0; k < 8; k++) begin
      s = c[4*k +: 3];
      f[k] = (at_en && c[4*k+3] && (s == eis_pkg::SENSE_LOW || s == eis_pkg::SENSE_RISE ||
        s == eis_pkg::SENSE_BOTH)) || s == eis_pkg::SENSE_HIGH;
    end
    return f;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One classic cycle; the request holds until ack is sampled, then idles one cycle.
  task automatic bus(input logic w, input logic [7:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    int i;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= d;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (i >= 20) begin
      chk("bus_ack", {31'h0, ack}, 32'h1);
      test_done();
    end
    rdat = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic pulse(input int ln);
    pm_u.set_pin(ln, 1'b0);
    repeat (12) @(posedge clk);
    pm_u.set_pin(ln, 1'b1);
    repeat (16) @(posedge clk);
  endtask

  // Watchdog against a hung run.
  initial begin
    repeat (20000) @(posedge clk);
    chk("watchdog", 32'h1, 32'h0);
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    {cyc, stb, we, standby, ulp_run} = 5'h0;
    adr = 8'h0;
    sel = 4'h0;
    wdat = 32'h0;
    seed = 8'h53;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // Reset values, including one unmapped word that also ignores writes.
    bus(1'b1, 8'h20, 4'hf, 32'hffff_ffff);
    for (int a = 0; a < 9; a++) begin
      bus(1'b0, 8'(4 * a), 4'hf, 32'h0);
      chk("reset_word", rdat, 32'h0);
    end
    $display("test reset values done");
    // Narrow writes to the async select word are replicated across lanes.
    for (int l = 0; l < 4; l++) begin
      seed = lfsr(seed);
      q = {4{~seed}};
      q[8*l +: 8] = seed;
      bus(1'b1, eis_pkg::ADDR_ASYNC, 4'(1 << l), q);
      bus(1'b0, eis_pkg::ADDR_ASYNC, 4'hf, 32'h0);
      chk("async_byte", rdat, {4{seed}});
    end
    for (int h = 0; h < 2; h++) begin
      seed = lfsr(seed);
      hb = lfsr(seed);
      q = h ? {hb, seed, ~hb, ~seed} : {~hb, ~seed, hb, seed};
      bus(1'b1, eis_pkg::ADDR_ASYNC, h ? eis_pkg::SEL_HI_HALF : eis_pkg::SEL_LO_HALF, q);
      bus(1'b0, eis_pkg::ADDR_ASYNC, 4'hf, 32'h0);
      chk("async_half", rdat, {2{hb, seed}});
    end
    q = {seed, hb, ~seed, 8'h5a};
    bus(1'b1, eis_pkg::ADDR_ASYNC, 4'hf, q);
    bus(1'b0, eis_pkg::ADDR_ASYNC, 4'hf, 32'h0);
    chk("async_word", rdat, q);
    bus(1'b1, eis_pkg::ADDR_ASYNC, 4'hf, 32'h0);
    $display("test async select done");
    // Random line setups, then enable: spurious flags and write-one-clear.
    for (int k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      cfg[4*k +: 4] = {seed[7], 3'(seed % 6)};
    end
    bus(1'b1, eis_pkg::ADDR_CFG0, 4'hf, cfg);
    bus(1'b1, eis_pkg::ADDR_CTRL, 4'hf, 32'h1);
    repeat (6) @(posedge clk);
    bus(1'b0, eis_pkg::ADDR_FLAGS, 4'hf, 32'h0);
    chk("enable_flags", rdat, spur(cfg, 1'b1));
    bus(1'b1, eis_pkg::ADDR_FLAGS, 4'hf, 32'h0);
    bus(1'b0, eis_pkg::ADDR_FLAGS, 4'hf, 32'h0);
    chk("flags_zero_write", rdat, spur(cfg, 1'b1));
    bus(1'b1, eis_pkg::ADDR_FLAGS, 4'hf, 32'hffff);
    repeat (4) @(posedge clk);
    bus(1'b0, eis_pkg::ADDR_FLAGS, 4'hf, 32'h0);
    chk("flags_cleared", rdat, spur(cfg, 1'b0));
    $display("test enable done");
    // Synchronous rising edge on line 3 with its interrupt unmasked.
    bus(1'b1, eis_pkg::ADDR_CFG0, 4'hf, 32'h0000_1000);
    bus(1'b1, eis_pkg::ADDR_IRQ_EN, 4'hf, 32'h8);
    pm_u.set_pin(3, 1'b0);
    repeat (6) @(posedge clk);
    bus(1'b1, eis_pkg::ADDR_FLAGS, 4'hf, 32'hffff);
    // The interrupt output trails the flags by a cycle, so let the clear reach it.
    repeat (2) @(posedge clk);
    chk("irq_idle", {31'h0, irq}, 32'h0);
    base = ev_cnt;
    pm_u.set_pin(3, 1'b1);
    repeat (12) @(posedge clk);
    chk("sync_events", 32'(ev_cnt - base), 32'h1);
    chk("irq_raised", {31'h0, irq}, 32'h1);
    bus(1'b1, eis_pkg::ADDR_FLAGS, 4'hf, 32'h8);
    repeat (3) @(posedge clk);
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    // Slow oscillator as detect clock: no tick, no detection.
    bus(1'b1, eis_pkg::ADDR_CTRL, 4'hf, 32'h3);
    ulp_run <= 1'b1;
    pm_u.set_pin(3, 1'b0);
    repeat (40) @(posedge clk);
    ulp_run <= 1'b0;
    repeat (8) @(posedge clk);
    base = ev_cnt;
    pm_u.set_pin(3, 1'b1);
    repeat (30) @(posedge clk);
    chk("no_tick_events", 32'(ev_cnt - base), 32'h0);
    ulp_run <= 1'b1;
    repeat (40) @(posedge clk);
    chk("tick_events", 32'(ev_cnt - base), 32'h1);
    bus(1'b1, eis_pkg::ADDR_CTRL, 4'hf, 32'h1);
    $display("test detect clock done");
    // Asynchronous line 4 in standby: one event, then none until wake.
    pm_u.set_pin(4, 1'b0);
    bus(1'b1, eis_pkg::ADDR_CFG0, 4'hf, 32'h0001_0000);
    bus(1'b1, eis_pkg::ADDR_ASYNC, 4'hf, 32'h10);
    standby <= 1'b1;
    repeat (6) @(posedge clk);
    base = ev_cnt;
    for (int p = 0; p < 3; p++) begin
      pulse(4);
    end
    chk("standby_events", 32'(ev_cnt - base), 32'h1);
    bus(1'b0, eis_pkg::ADDR_FLAGS, 4'hf, 32'h0);
    chk("standby_flag", {31'h0, rdat[4]}, 32'h1);
    standby <= 1'b0;
    repeat (4) @(posedge clk);
    base = ev_cnt;
    pulse(4);
    chk("wake_events", 32'(ev_cnt - base), 32'h1);
    $display("test standby done");
    // Nonmaskable sense change while running gives a false flag, cleared by one.
    bus(1'b1, eis_pkg::ADDR_NMI_CFG, 4'hf, {29'h0, eis_pkg::SENSE_RISE});
    repeat (4) @(posedge clk);
    chk("nmi_false", {31'h0, nmi}, 32'h1);
    bus(1'b1, eis_pkg::ADDR_NMI_FLAG, 4'hf, 32'h1);
    repeat (2) @(posedge clk);
    chk("nmi_cleared", {31'h0, nmi}, 32'h0);
    bus(1'b0, eis_pkg::ADDR_NMI_FLAG, 4'hf, 32'h0);
    chk("nmi_flag_word", rdat, 32'h0);
    // A real rising edge on the nonmaskable pin sets the flag, and a zero write keeps it.
    pm_u.set_nmi(1'b1);
    repeat (6) @(posedge clk);
    chk("nmi_pin_rise", {31'h0, nmi}, 32'h1);
    bus(1'b1, eis_pkg::ADDR_NMI_FLAG, 4'hf, 32'h0);
    repeat (2) @(posedge clk);
    chk("nmi_zero_write", {31'h0, nmi}, 32'h1);
    $display("test nonmaskable done");
    test_done();
  end
endmodule

`default_nettype wire
